// [shared/bbg_pkg.sv]
// Shared constants and types for the board bus glue decode block
package bbg_pkg;
    // ------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------
    localparam int SYS_CLK_MHZ     = 200;
    localparam int SYS_PERIOD_NS   = 5;
    localparam int CPU_FAST_MHZ    = 4;
    localparam int CPU_SLOW_MHZ    = 2;
    localparam int DIV_FAST        = SYS_CLK_MHZ / CPU_FAST_MHZ;
    localparam int DIV_SLOW        = SYS_CLK_MHZ / CPU_SLOW_MHZ;
    localparam int DIV_W           = 7;
    localparam int SLOW_MEM_NS     = 300;
    localparam int WAIT_CYCLES     = (SLOW_MEM_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
    localparam int WAIT_W          = 7;
    localparam int POC_CYCLES      = 16;
    localparam int POC_W           = 5;

    // ------------------------------------------------------------
    // I/O map, byte offsets within the 8-bit I/O space
    // ------------------------------------------------------------
    localparam logic [7:0] SER_DATA_OFS      = 8'h04;
    localparam logic [7:0] SER_CTRL_OFS      = 8'h05;
    localparam logic [7:0] SER_DATA_ECHO_OFS = 8'h06;
    localparam logic [7:0] SER_CTRL_ECHO_OFS = 8'h07;
    localparam logic [7:0] PAR_FIRST_OFS     = 8'h08;
    localparam logic [7:0] PAR_SECOND_OFS    = 8'h09;
    localparam logic [7:0] PAR_THIRD_OFS     = 8'h0A;
    localparam logic [7:0] PAR_CSR_OFS       = 8'h0B;
    localparam int         GROUP_LSB         = 2;
    localparam int         CTRL_BIT          = 0;
    localparam logic [1:0] PAR_CSR_IDX       = 2'h3;
    localparam int         PAR_CHANNELS      = 3;
    localparam logic [7:0] PAR_CSR_RESET     = 8'hFF;

    // ------------------------------------------------------------
    // Memory map
    // ------------------------------------------------------------
    localparam logic [15:0] BOOT_ADDR   = 16'hE000;
    localparam logic [15:0] EPROM_FIRST = 16'hE000;
    localparam logic [15:0] EPROM_LAST  = 16'hE7FF;
    localparam int          BOOT_MSB_W  = 3;

    // ------------------------------------------------------------
    // Jumper settings
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        BBG_WAIT_NONE  = 2'b00,
        BBG_WAIT_FETCH = 2'b01,
        BBG_WAIT_ALL   = 2'b10
    } bbg_wait_mode_t;

    typedef struct packed {
        logic [5:0]     ser_base;
        logic [5:0]     par_base;
        bbg_wait_mode_t wait_mode;
        logic           auto_boot;
        logic           mwrite_en;
        logic           phantom_en;
        logic           clk_fast;
    } bbg_jumper_t;

    localparam int JUMPER_W = $bits(bbg_jumper_t);

    localparam bbg_jumper_t JUMPER_SHIPPED = '{
        ser_base:   SER_DATA_OFS[7:2],
        par_base:   PAR_FIRST_OFS[7:2],
        wait_mode:  BBG_WAIT_FETCH,
        auto_boot:  1'b1,
        mwrite_en:  1'b1,
        phantom_en: 1'b1,
        clk_fast:   1'b1
    };

    // Processor bus request, all strobes active high
    typedef struct packed {
        logic [15:0] addr;
        logic [7:0]  wdata;
        logic        mreq;
        logic        iorq;
        logic        rd;
        logic        wr;
        logic        fetch;
        logic        refresh;
    } bbg_cpu_req_t;
endpackage : bbg_pkg

// [hdl/bbg_sync.sv]
// Two-stage synchroniser for pin inputs
`timescale 1ns/1ps
module bbg_sync #(
    parameter int W = 1
) (
    input  wire logic         i_clock,
    input  wire logic         i_srst,
    input  wire logic [W-1:0] i_async,
    output logic      [W-1:0] o_sync
);
    logic [W-1:0] stage1;

    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            stage1 <= '0;
            o_sync <= '0;
        end else begin
            stage1 <= i_async;
            o_sync <= stage1;
        end
    end
endmodule : bbg_sync

// [hdl/bbg_clkdiv.sv]
// Divider giving a one-cycle processor clock enable
`timescale 1ns/1ps
module bbg_clkdiv #(
    parameter int W = 7
) (
    input  wire logic         i_clock,
    input  wire logic         i_srst,
    input  wire logic [W-1:0] i_divide,
    output logic              o_tick
);
    logic [W-1:0] count;

    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            count  <= '0;
            o_tick <= 1'b0;
        end else if (count >= i_divide - W'(1)) begin
            count  <= '0;
            o_tick <= 1'b1;
        end else begin
            count  <= count + W'(1);
            o_tick <= 1'b0;
        end
    end
endmodule : bbg_clkdiv

// [hdl/bbg_glue.sv]
// Board bus glue: I/O decode, wait states, boot jump and backplane strobes
`timescale 1ns/1ps
module bbg_glue #(
    parameter int POC_LEN  = bbg_pkg::POC_CYCLES,
    parameter int WAIT_LEN = bbg_pkg::WAIT_CYCLES
) (
    input  wire logic                 i_clock,
    input  wire logic                 i_srst,
    input  wire bbg_pkg::bbg_cpu_req_t i_cpu,
    input  wire bbg_pkg::bbg_jumper_t i_jumper,
    input  wire logic                 i_phantom,
    input  wire logic [23:0]          i_par_pins,
    output logic                      o_cpu_clk_en,
    output logic                      o_cpu_wait,
    output logic [7:0]                o_cpu_rdata,
    output logic                      o_cpu_rdata_valid,
    output logic [15:0]               o_bus_addr,
    output logic                      o_bus_mwrite,
    output logic                      o_bus_refresh,
    output logic                      o_bus_buf_en,
    output logic                      o_power_on_clear_pulse,
    output logic                      o_eprom_sel,
    output logic                      o_ser_sel,
    output logic                      o_ser_ctrl,
    output logic                      o_ser_rd,
    output logic                      o_ser_wr,
    output logic [23:0]               o_par_out,
    output logic [2:0]                o_par_oe,
    output logic [7:0]                o_par_csr
);
    import bbg_pkg::*;

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [JUMPER_W-1:0] jumper_raw;
    logic                phantom_sync;
    logic [23:0]         par_in_sync;

    bbg_sync #(.W(JUMPER_W)) u_sync_jumper (
        .i_clock (i_clock),
        .i_srst  (i_srst),
        .i_async (i_jumper),
        .o_sync  (jumper_raw)
    );

    bbg_sync #(.W(25)) u_sync_pins (
        .i_clock (i_clock),
        .i_srst  (i_srst),
        .i_async ({i_phantom, i_par_pins}),
        .o_sync  ({phantom_sync, par_in_sync})
    );

    // ------------------------------------------------------------
    // Jumper capture
    // ------------------------------------------------------------
    // Shipped settings stand until the synchronisers have filled
    bbg_jumper_t jumper;
    logic [1:0]  settle;

    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            settle <= 2'h0;
        end else if (settle != 2'h3) begin
            settle <= settle + 2'h1;
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            jumper <= JUMPER_SHIPPED;
        end else if (settle == 2'h3) begin
            jumper <= bbg_jumper_t'(jumper_raw);
        end
    end

    // ------------------------------------------------------------
    // Processor clock enable
    // ------------------------------------------------------------
    logic [DIV_W-1:0] divide;
    logic             cpu_tick;

    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            divide <= DIV_W'(DIV_FAST);
        end else begin
            divide <= jumper.clk_fast ? DIV_W'(DIV_FAST) : DIV_W'(DIV_SLOW);
        end
    end

    bbg_clkdiv #(.W(DIV_W)) u_clkdiv (
        .i_clock  (i_clock),
        .i_srst   (i_srst),
        .i_divide (divide),
        .o_tick   (cpu_tick)
    );

    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            o_cpu_clk_en <= 1'b0;
        end else begin
            o_cpu_clk_en <= cpu_tick;
        end
    end

    // ------------------------------------------------------------
    // Power-on clear pulse
    // ------------------------------------------------------------
    logic [POC_W-1:0] poc_count;

    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            poc_count              <= '0;
            o_power_on_clear_pulse <= 1'b1;
        end else if (poc_count != POC_W'(POC_LEN)) begin
            poc_count              <= poc_count + POC_W'(1);
            o_power_on_clear_pulse <= 1'b1;
        end else begin
            o_power_on_clear_pulse <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Auto-boot address override
    // ------------------------------------------------------------
    // Top bits are forced until the code at the boot address has
    // jumped into the monitor region under its own addressing.
    logic        boot_pending;
    logic [15:0] next_bus_addr;

    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            boot_pending <= 1'b1;
        end else if (!jumper.auto_boot) begin
            boot_pending <= 1'b0;
        end else if (boot_pending && i_cpu.mreq && i_cpu.fetch
                     && i_cpu.addr[15 -: BOOT_MSB_W] == BOOT_ADDR[15 -: BOOT_MSB_W]) begin
            boot_pending <= 1'b0;
        end
    end

    always_comb begin
        next_bus_addr = i_cpu.addr;
        if (boot_pending && jumper.auto_boot && i_cpu.mreq) begin
            next_bus_addr = i_cpu.addr | BOOT_ADDR;
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            o_bus_addr <= BOOT_ADDR;
        end else begin
            o_bus_addr <= next_bus_addr;
        end
    end

    // ------------------------------------------------------------
    // Memory decode and backplane strobes
    // ------------------------------------------------------------
    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            o_eprom_sel <= 1'b0;
        end else begin
            o_eprom_sel <= i_cpu.mreq && !i_cpu.refresh
                           && next_bus_addr >= EPROM_FIRST
                           && next_bus_addr <= EPROM_LAST;
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            o_bus_mwrite <= 1'b0;
        end else begin
            o_bus_mwrite <= jumper.mwrite_en && i_cpu.mreq
                            && i_cpu.wr && !i_cpu.iorq;
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            o_bus_refresh <= 1'b0;
        end else begin
            o_bus_refresh <= i_cpu.refresh;
        end
    end

    // Another board's phantom turns our drivers off
    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            o_bus_buf_en <= 1'b0;
        end else begin
            o_bus_buf_en <= !(jumper.phantom_en && phantom_sync);
        end
    end

    // ------------------------------------------------------------
    // Wait-state generator
    // ------------------------------------------------------------
    logic              cycle_prev;
    logic              cycle_start;
    logic              wait_wanted;
    logic [WAIT_W-1:0] wait_count;

    assign cycle_start = (i_cpu.mreq || i_cpu.iorq) && !i_cpu.refresh && !cycle_prev;

    always_comb begin
        unique case (jumper.wait_mode)
            BBG_WAIT_ALL:   wait_wanted = 1'b1;
            BBG_WAIT_FETCH: wait_wanted = i_cpu.fetch;
            BBG_WAIT_NONE:  wait_wanted = 1'b0;
            default:        wait_wanted = 1'b0;
        endcase
    end

    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            cycle_prev <= 1'b0;
        end else begin
            cycle_prev <= (i_cpu.mreq || i_cpu.iorq) && !i_cpu.refresh;
        end
    end

    // One stretch long enough for a memory as slow as the limit
    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            wait_count <= '0;
            o_cpu_wait <= 1'b0;
        end else if (cycle_start && wait_wanted) begin
            wait_count <= WAIT_W'(WAIT_LEN - 1);
            o_cpu_wait <= 1'b1;
        end else if (wait_count != '0) begin
            wait_count <= wait_count - WAIT_W'(1);
            o_cpu_wait <= 1'b1;
        end else begin
            o_cpu_wait <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // I/O decode
    // ------------------------------------------------------------
    logic       io_access;
    logic       io_first;
    logic       ser_hit;
    logic       par_hit;
    logic [1:0] par_idx;

    assign io_access = i_cpu.iorq && !i_cpu.fetch;
    assign io_first  = io_access && !cycle_prev;
    assign ser_hit   = io_access
                       && i_cpu.addr[7:GROUP_LSB] == jumper.ser_base;
    assign par_hit   = io_access
                       && i_cpu.addr[7:GROUP_LSB] == jumper.par_base;
    assign par_idx   = i_cpu.addr[1:0];

    // Serial controller selects; bit 1 is left out so 06H/07H echo 04H/05H
    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            o_ser_sel  <= 1'b0;
            o_ser_ctrl <= 1'b0;
            o_ser_rd   <= 1'b0;
            o_ser_wr   <= 1'b0;
        end else begin
            o_ser_sel  <= ser_hit;
            o_ser_ctrl <= ser_hit && i_cpu.addr[CTRL_BIT];
            o_ser_rd   <= ser_hit && i_cpu.rd;
            o_ser_wr   <= ser_hit && i_cpu.wr;
        end
    end

    // ------------------------------------------------------------
    // Parallel channels
    // ------------------------------------------------------------
    // A set control bit makes that channel an input
    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            o_par_csr <= PAR_CSR_RESET;
        end else if (par_hit && io_first && i_cpu.wr && par_idx == PAR_CSR_IDX) begin
            o_par_csr <= i_cpu.wdata;
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            o_par_oe <= 3'h0;
        end else begin
            o_par_oe <= ~o_par_csr[2:0];
        end
    end

    for (genvar ch = 0; ch < PAR_CHANNELS; ch++) begin : g_par
        always_ff @(posedge i_clock) begin
            if (i_srst) begin
                o_par_out[ch*8 +: 8] <= 8'h00;
            end else if (par_hit && io_first && i_cpu.wr && par_idx == 2'(ch)) begin
                o_par_out[ch*8 +: 8] <= i_cpu.wdata;
            end
        end
    end

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    // Inputs are not latched: the pins are caught only at the read
    logic [7:0] next_rdata;

    always_comb begin
        next_rdata = 8'h00;
        if (par_idx == PAR_CSR_IDX) begin
            next_rdata = o_par_csr;
        end else if (o_par_csr[par_idx]) begin
            next_rdata = par_in_sync[par_idx*8 +: 8];
        end else begin
            next_rdata = o_par_out[par_idx*8 +: 8];
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            o_cpu_rdata       <= 8'h00;
            o_cpu_rdata_valid <= 1'b0;
        end else if (par_hit && io_first && i_cpu.rd) begin
            o_cpu_rdata       <= next_rdata;
            o_cpu_rdata_valid <= 1'b1;
        end else begin
            o_cpu_rdata_valid <= 1'b0;
        end
    end
endmodule : bbg_glue

// [verification/bbg_backplane.sv]
// Backplane partner: phantom-asserting memory board and parallel pin wiring
`timescale 1ns/1ps
module bbg_backplane (
    input  wire logic        i_clock,
    input  wire logic        i_poc,
    input  wire logic        i_force_phantom,
    input  wire logic [23:0] i_drive,
    input  wire logic [23:0] i_dut_out,
    input  wire logic [2:0]  i_dut_oe,
    output logic             o_phantom,
    output logic [23:0]      o_pins
);
    initial o_phantom = 1'h0;
    // Memory boards answer power-on clear one clock late
    always @(posedge i_clock) begin
        o_phantom <= i_poc | i_force_phantom;
    end
    // Wire level: the block wins where it drives, the far side elsewhere
    always_comb begin
        for (int c = 0; c < 3; c++) begin
            o_pins[8*c +: 8] = i_dut_oe[c] ? i_dut_out[8*c +: 8] : i_drive[8*c +: 8];
        end
    end
endmodule : bbg_backplane

// [verification/bbg_glue_props.sv]
// Concurrent checks on the board bus glue ports
`timescale 1ns/1ps
module bbg_glue_props
    import bbg_pkg::*;
#(
    parameter int POC_LEN  = POC_CYCLES,
    parameter int WAIT_LEN = WAIT_CYCLES
) (
    input wire logic         i_clock,
    input wire logic         i_srst,
    input wire bbg_cpu_req_t i_cpu,
    input wire logic         i_phantom,
    input wire logic         o_cpu_clk_en,
    input wire logic         o_cpu_wait,
    input wire logic         o_cpu_rdata_valid,
    input wire logic [15:0]  o_bus_addr,
    input wire logic         o_bus_mwrite,
    input wire logic         o_bus_buf_en,
    input wire logic         o_power_on_clear_pulse,
    input wire logic         o_eprom_sel,
    input wire logic         o_ser_sel,
    input wire logic         o_ser_ctrl,
    input wire logic [23:0]  o_par_out,
    input wire logic [7:0]   o_par_csr
);
    logic [7:0] since;
    logic [7:0] wait_cnt;
    logic [7:0] gap_cnt;
    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (i_srst);
    // --------------
    // Helper counters
    // --------------
    // Synchronisers need a few clocks after reset before pins count
    always_ff @(posedge i_clock) begin
        if (i_srst) since <= 8'h00;
        else if (since != 8'hFF) since <= since + 8'h01;
    end
    always_ff @(posedge i_clock) begin
        wait_cnt <= (i_srst || !o_cpu_wait) ? 8'h00 : wait_cnt + 8'h01;
    end
    always_ff @(posedge i_clock) begin
        if (i_srst || o_cpu_clk_en) gap_cnt <= 8'h00;
        else if (gap_cnt != 8'hFF) gap_cnt <= gap_cnt + 8'h01;
    end
    sequence valid_drop;
        $past(i_cpu.iorq & i_cpu.rd) ##1 !o_cpu_rdata_valid;
    endsequence
    // ----------
    // Assertions
    // ----------
    reset_vals_a: assert property ($fell(i_srst) |-> o_power_on_clear_pulse
        && o_bus_addr == 16'hE000 && o_par_csr == 8'hFF) else $error("reset values wrong");
    poc_hold_a: assert property ($fell(o_power_on_clear_pulse) |-> since >= POC_LEN)
        else $error("power-on clear too short");
    wait_len_a: assert property ($fell(o_cpu_wait) |-> wait_cnt == WAIT_LEN)
        else $error("wait length wrong");
    wait_cause_a: assert property ($rose(o_cpu_wait) |->
        $past(i_cpu.mreq | i_cpu.iorq) && !$past(i_cpu.refresh)) else $error("stray wait");
    mwrite_cause_a: assert property (o_bus_mwrite |->
        $past(i_cpu.mreq & i_cpu.wr & ~i_cpu.iorq)) else $error("stray mwrite");
    eprom_range_a: assert property (o_eprom_sel |-> o_bus_addr[15:11] == 5'h1C
        && $past(i_cpu.mreq & ~i_cpu.refresh)) else $error("eprom select outside range");
    ser_ctrl_a: assert property (o_ser_sel |->
        o_ser_ctrl == $past(i_cpu.addr[0]) && $past(i_cpu.iorq)) else $error("serial decode");
    buf_off_a: assert property (since >= 8'h07 && !o_bus_buf_en |->
        $past(i_phantom, 3)) else $error("buffers off without phantom");
    par_latch_a: assert property ($changed(o_par_out) |->
        $past(i_cpu.iorq & i_cpu.wr)) else $error("latch moved without write");
    rdata_pulse_a: assert property (o_cpu_rdata_valid |-> valid_drop)
        else $error("read valid wrong");
    tick_gap_a: assert property (o_cpu_clk_en |-> gap_cnt < 8'h64)
        else $error("clock enable gap too long");
endmodule : bbg_glue_props
bind bbg_glue bbg_glue_props #(.POC_LEN(POC_LEN), .WAIT_LEN(WAIT_LEN)) props_u (
    .i_clock(i_clock), .i_srst(i_srst), .i_cpu(i_cpu), .i_phantom(i_phantom),
    .o_cpu_clk_en(o_cpu_clk_en), .o_cpu_wait(o_cpu_wait),
    .o_cpu_rdata_valid(o_cpu_rdata_valid), .o_bus_addr(o_bus_addr),
    .o_bus_mwrite(o_bus_mwrite), .o_bus_buf_en(o_bus_buf_en),
    .o_power_on_clear_pulse(o_power_on_clear_pulse), .o_eprom_sel(o_eprom_sel),
    .o_ser_sel(o_ser_sel), .o_ser_ctrl(o_ser_ctrl), .o_par_out(o_par_out),
    .o_par_csr(o_par_csr));

// [verification/test_board_bus_glue_decode.sv]
// Self-checking bench for the board bus glue decode block
`timescale 1ns/1ps
module test_board_bus_glue_decode;
    import bbg_pkg::*;
    localparam int POWER_ON_CLEAR_PULSE = 8;
    localparam int WLEN = 4;
    localparam int LIMIT = 5000;
    localparam logic [5:0] MRD = 6'h28, MFE = 6'h2A, MWR = 6'h24;
    localparam logic [5:0] IRD = 6'h18, IWR = 6'h14, RFS = 6'h21;
    logic         clk = 1'h0;
    logic         rst = 1'h1;
    bbg_cpu_req_t cpu = '0;
    bbg_jumper_t  jmp = JUMPER_SHIPPED;
    logic         force_ph = 1'h0;
    logic [23:0]  pin_drv = 24'h000000;
    logic         phantom, cke, wt, rdv, mwr, refresh_strobe, bufen, power_on_clear_pulse, esel;
    logic         ssel, sctl, srd, swr;
    logic [7:0]   rdat, csr;
    logic [15:0]  baddr;
    logic [23:0]  pins, pout;
    logic [2:0]   poe;
    int           failures = 0;
    int           total_checks = 0;
    int           cycles = 0;
    bbg_glue #(.POC_LEN(POWER_ON_CLEAR_PULSE), .WAIT_LEN(WLEN)) dut_u (
        .i_clock(clk), .i_srst(rst), .i_cpu(cpu), .i_jumper(jmp), .i_phantom(phantom),
        .i_par_pins(pins), .o_cpu_clk_en(cke), .o_cpu_wait(wt), .o_cpu_rdata(rdat),
        .o_cpu_rdata_valid(rdv), .o_bus_addr(baddr), .o_bus_mwrite(mwr),
        .o_bus_refresh(refresh_strobe), .o_bus_buf_en(bufen), .o_power_on_clear_pulse(power_on_clear_pulse),
        .o_eprom_sel(esel), .o_ser_sel(ssel), .o_ser_ctrl(sctl), .o_ser_rd(srd),
        .o_ser_wr(swr), .o_par_out(pout), .o_par_oe(poe), .o_par_csr(csr));
    bbg_backplane far_u (
        .i_clock(clk), .i_poc(power_on_clear_pulse), .i_force_phantom(force_ph), .i_drive(pin_drv),
        .i_dut_out(pout), .i_dut_oe(poe), .o_phantom(phantom), .o_pins(pins));
    always #2.5 clk = ~clk;
    always @(posedge clk) begin
        cycles++;
        if (cycles == LIMIT) begin
            failures++;
            finish_test();
        end
    end
    // ----------------
    // Shared helpers
    // ----------------
    task automatic finish_test;
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : finish_test
    task automatic chk(input string nm, input logic [23:0] exp, input logic [23:0] got);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask : tick
    // One idle cycle then one request cycle; outputs settled on return
    task automatic cyc(input logic [15:0] a, input logic [7:0] d, input logic [5:0] k);
        @(negedge clk);
        cpu = {a, d, k};
        @(negedge clk);
        cpu = '0;
    endtask : cyc
    // ----------
    // Scenarios
    // ----------
    task automatic t_reset;
        int n;
        chk("poc_in_reset", 1'h1, power_on_clear_pulse);
        chk("addr_in_reset", 16'hE000, baddr);
        rst = 1'h0;
        n = 0;
        while (power_on_clear_pulse === 1'h1 && n < 40) begin
            @(negedge clk);
            n++;
        end
        chk("poc_length", 1'h1, n >= POWER_ON_CLEAR_PULSE && n <= POWER_ON_CLEAR_PULSE + 2);
        chk("phantom_hold", 1'h0, bufen);
        tick(8);
        chk("phantom_gone", 1'h1, bufen);
    endtask : t_reset
    task automatic t_boot;
        logic [15:0] ea [4] = '{16'hE000, 16'hE7FF, 16'hE800, 16'hDFFF};
        cyc(16'h0000, 8'h00, MFE);
        chk("boot_addr", 16'hE000, baddr);
        chk("boot_rom", 1'h1, esel);
        chk("fetch_wait", 1'h1, wt);
        tick(WLEN + 2);
        cyc(16'hE003, 8'h00, MFE);
        tick(WLEN + 2);
        cyc(16'h0100, 8'h00, MRD);
        chk("boot_done", 16'h0100, baddr);
        chk("plain_wait", 1'h0, wt);
        for (int i = 0; i < 4; i++) begin
            cyc(ea[i], 8'h00, MRD);
            chk("rom_window", i < 2, esel);
        end
    endtask : t_boot
    task automatic t_wait;
        int n;
        for (int i = 0; i < 3; i++) begin
            jmp.wait_mode = bbg_wait_mode_t'(i);
            tick(8);
            cyc(16'h0200, 8'h00, MRD);
            chk("wait_plain", i == 2, wt);
            tick(WLEN + 2);
            cyc(16'h0201, 8'h00, MFE);
            chk("wait_fetch", i != 0, wt);
            n = 0;
            while (wt === 1'h1 && n < 200) begin
                @(negedge clk);
                n++;
            end
            if (i != 0) chk("wait_len", WLEN, n);
            tick(2);
        end
        cyc(16'h0042, 8'h00, RFS);
        chk("refresh_nowait", 1'h0, wt);
        chk("refresh_fwd", 1'h1, refresh_strobe);
        jmp = JUMPER_SHIPPED;
    endtask : t_wait
    task automatic t_io(input logic [7:0] sb, input logic [7:0] pb);
        logic [7:0] a;
        logic       hit;
        for (int i = 0; i < 6; i++) begin
            a = sb + 8'(i) - 8'h01;
            hit = i >= 1 && i <= 4;
            cyc({8'h00, a}, 8'h00, IRD);
            chk("ser_sel", hit, ssel);
            if (hit) chk("ser_ctrl", a[0], sctl);
            if (hit) chk("ser_rd", 1'h1, srd);
        end
        cyc({8'h00, sb + 8'h03}, 8'h00, IWR);
        chk("ser_wr", 1'h1, swr);
        // Interrupt acknowledge carries iorq with fetch and is no access
        cyc({8'h00, sb}, 8'h00, IRD | 6'h02);
        chk("intack_ignored", 1'h0, ssel);
        cyc({8'h00, pb + 8'h03}, 8'h01, IWR);
        chk("csr_reg", 8'h01, csr);
        // Drive enables follow the control register one clock later
        tick(1);
        chk("par_oe", 3'h6, poe);
        cyc({8'h00, pb + 8'h01}, 8'h5A ^ pb, IWR);
        cyc({8'h00, pb + 8'h02}, 8'hC3 ^ pb, IWR);
        chk("par_out", {8'hC3 ^ pb, 8'h5A ^ pb}, pout[23:8]);
        cyc({8'h00, pb + 8'h03}, 8'h00, IRD);
        chk("csr_read", 8'h01, rdat);
        for (int v = 0; v < 2; v++) begin
            pin_drv = v ? 24'h00003C : 24'h0000A5;
            tick(3);
            cyc({8'h00, pb}, 8'h00, IRD);
            chk("pin_read", pin_drv[7:0], rdat);
            chk("read_valid", 1'h1, rdv);
        end
        cyc({8'h00, pb + 8'h01}, 8'h00, IRD);
        chk("latch_read", 8'h5A ^ pb, rdat);
    endtask : t_io
    task automatic t_strobes;
        cyc(16'h1234, 8'h77, MWR);
        chk("mwrite_on", 1'h1, mwr);
        jmp.mwrite_en = 1'h0;
        tick(8);
        cyc(16'h1234, 8'h77, MWR);
        chk("mwrite_off", 1'h0, mwr);
        force_ph = 1'h1;
        tick(6);
        chk("phantom_off", 1'h0, bufen);
        jmp.phantom_en = 1'h0;
        tick(8);
        chk("phantom_ignored", 1'h1, bufen);
        force_ph = 1'h0;
        jmp = JUMPER_SHIPPED;
    endtask : t_strobes
    task automatic t_clock(input logic fast);
        int n;
        jmp.clk_fast = fast;
        tick(8);
        for (int k = 0; k < 3; k++) begin
            n = 0;
            do begin
                @(negedge clk);
                n++;
            end while (cke !== 1'h1 && n < 300);
        end
        chk("tick_period", fast ? DIV_FAST : DIV_SLOW, n);
    endtask : t_clock
    initial begin
        tick(4);
        t_reset();
        t_boot();
        t_wait();
        t_io(8'h04, 8'h08);
        jmp.ser_base = 6'h3F;
        jmp.par_base = 6'h00;
        tick(8);
        t_io(8'hFC, 8'h00);
        jmp = JUMPER_SHIPPED;
        tick(8);
        t_strobes();
        t_clock(1'h1);
        t_clock(1'h0);
        finish_test();
    end
endmodule : test_board_bus_glue_decode
